// ===== src/hmbt_pkg.sv
// Shared constants for the host to micro bus translator
package hmbt_pkg;
    localparam int DATA_W = 8;
    localparam int HADDR_W = 4;
    localparam int SEL_W = 3;
    // Port select bit: 0 = command/report, 1 = data
    localparam int SEL_DATA_BIT = 0;
    localparam logic SEL_CTRL = 1'b0;
    localparam logic SEL_DATA = 1'b1;
    // Outer and middle bits of command and report ports
    localparam int ATTN_BIT = 0;
    localparam int OUTER_BIT = 7;
    localparam int MID_LO = 1;
    localparam int MID_HI = 6;
    // Values after reset
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [5:0] MID_RST = 6'h00;
    localparam logic FLAG_RST = 1'b0;
endpackage : hmbt_pkg

// ===== src/hmbt_sync.sv
// Two flip-flop synchroniser for pin inputs
module hmbt_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // hmbt_sync

// ===== src/hmbt_strobe.sv
// Strobe edge detector: one-cycle pulse on rising edge of a synced strobe
module hmbt_strobe (
    input wire logic clk,
    input wire logic rst,
    input wire logic strobe_pin,
    output logic level,
    output logic pulse
);
    logic prev_q;

    hmbt_sync #(.W(1)) u_sync (
        .clk(clk),
        .rst(rst),
        .d(strobe_pin),
        .q(level)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end

    assign pulse = level & ~prev_q;
endmodule // hmbt_strobe

// ===== src/hmbt_translator.sv
// Host to microcomputer bus translator: four mailbox registers
//
// Function
// - Four registers, two each direction: 8-bit data, 6-bit command/report
// - Host data write sets host_to_micro_full
// - Micro data read clears host_to_micro_full
// - Micro data write sets micro_to_host_full
// - Host data read clears micro_to_host_full
// - Host command bits 1-6 latched for micro
// - Host command bit 0 drives micro attention
// - Host command bit 7 drives micro reset
// - Micro command read: flags in bits 0/7
// - Micro report bits 1-6 latched for host
// - Micro report bit 0 drives host attention
// - Micro report bit 7 drives host halt
// - Host report read: flags in bits 0/7
// - Separate 8-bit write and read data paths per side, address steered
// - Upper address bits match select switches
// - Select bit plus strobe picks register
module hmbt_translator
    import hmbt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // Host side pins
    input wire logic [HADDR_W-1:0] host_address_bits,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [DATA_W-1:0] host_wdata,
    output logic [DATA_W-1:0] host_rdata,
    output logic host_rdata_oe_n,
    input wire logic [SEL_W-1:0] select_code_switches,
    output logic card_selected,
    output logic host_attention_request,
    output logic host_halt_request,
    // Microcomputer side pins
    input wire logic [DATA_W-1:0] micro_addr,
    input wire logic micro_rd,
    input wire logic micro_wr,
    input wire logic [DATA_W-1:0] micro_wdata,
    output logic [DATA_W-1:0] micro_rdata,
    output logic micro_rdata_oe_n,
    output logic micro_attention_request,
    output logic micro_reset,
    // Flag view
    output logic host_to_micro_full,
    output logic micro_to_host_full
);

    // =========================================================
    // Input synchronisers
    // =========================================================
    logic [HADDR_W-1:0] haddr_s;
    logic [SEL_W-1:0] sel_s;
    logic [DATA_W-1:0] hdat_s;
    logic [DATA_W-1:0] maddr_s;
    logic [DATA_W-1:0] mdat_s;
    logic hrd_lvl, hwr_lvl, mrd_lvl, mwr_lvl;
    logic hrd_p, hwr_p, mrd_p, mwr_p;

    hmbt_sync #(.W(HADDR_W)) u_haddr (
        .clk(clk), .rst(rst), .d(host_address_bits), .q(haddr_s)
    );
    hmbt_sync #(.W(SEL_W)) u_sel (
        .clk(clk), .rst(rst), .d(select_code_switches), .q(sel_s)
    );
    hmbt_sync #(.W(DATA_W)) u_hdat (
        .clk(clk), .rst(rst), .d(host_wdata), .q(hdat_s)
    );
    hmbt_sync #(.W(DATA_W)) u_maddr (
        .clk(clk), .rst(rst), .d(micro_addr), .q(maddr_s)
    );
    hmbt_sync #(.W(DATA_W)) u_mdat (
        .clk(clk), .rst(rst), .d(micro_wdata), .q(mdat_s)
    );
    hmbt_strobe u_hrd (
        .clk(clk), .rst(rst), .strobe_pin(host_rd),
        .level(hrd_lvl), .pulse(hrd_p)
    );
    hmbt_strobe u_hwr (
        .clk(clk), .rst(rst), .strobe_pin(host_wr),
        .level(hwr_lvl), .pulse(hwr_p)
    );
    hmbt_strobe u_mrd (
        .clk(clk), .rst(rst), .strobe_pin(micro_rd),
        .level(mrd_lvl), .pulse(mrd_p)
    );
    hmbt_strobe u_mwr (
        .clk(clk), .rst(rst), .strobe_pin(micro_wr),
        .level(mwr_lvl), .pulse(mwr_p)
    );

    // =========================================================
    // Address decode
    // =========================================================
    logic sel_match;
    logic h_data, m_data;
    logic h_wr_data, h_wr_cmd, h_rd_data, h_rd_rep;
    logic m_wr_data, m_wr_rep, m_rd_data, m_rd_cmd;

    assign sel_match = (haddr_s[HADDR_W-1:1] == sel_s);
    assign h_data = (haddr_s[SEL_DATA_BIT] == SEL_DATA);
    assign m_data = (maddr_s[SEL_DATA_BIT] == SEL_DATA);

    always_ff @(posedge clk) begin
        if (rst) begin
            card_selected <= 1'b0;
        end else begin
            card_selected <= sel_match;
        end
    end

    // Register chosen by select bit and strobe; host side also needs sel_match
    assign h_wr_data = sel_match & hwr_p & h_data;
    assign h_wr_cmd = sel_match & hwr_p & ~h_data;
    assign h_rd_data = sel_match & hrd_p & h_data;
    assign h_rd_rep = sel_match & hrd_p & ~h_data;
    assign m_wr_data = mwr_p & m_data;
    assign m_wr_rep = mwr_p & ~m_data;
    assign m_rd_data = mrd_p & m_data;
    assign m_rd_cmd = mrd_p & ~m_data;

    // =========================================================
    // Mailbox registers
    // =========================================================
    logic [DATA_W-1:0] h2m_data_q;
    logic [DATA_W-1:0] m2h_data_q;
    logic [MID_HI:MID_LO] cmd_mid_q;
    logic [MID_HI:MID_LO] rep_mid_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            h2m_data_q <= DATA_RST;
        end else if (h_wr_data) begin
            h2m_data_q <= hdat_s;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            m2h_data_q <= DATA_RST;
        end else if (m_wr_data) begin
            m2h_data_q <= mdat_s;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_mid_q <= MID_RST;
        end else if (h_wr_cmd) begin
            cmd_mid_q <= hdat_s[MID_HI:MID_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rep_mid_q <= MID_RST;
        end else if (m_wr_rep) begin
            rep_mid_q <= mdat_s[MID_HI:MID_LO];
        end
    end

    // =========================================================
    // Outer bits: request lines
    // =========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            micro_attention_request <= FLAG_RST;
            micro_reset <= FLAG_RST;
        end else if (h_wr_cmd) begin
            micro_attention_request <= hdat_s[ATTN_BIT];
            micro_reset <= hdat_s[OUTER_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            host_attention_request <= FLAG_RST;
            host_halt_request <= FLAG_RST;
        end else if (m_wr_rep) begin
            host_attention_request <= mdat_s[ATTN_BIT];
            host_halt_request <= mdat_s[OUTER_BIT];
        end
    end

    // =========================================================
    // Buffer full flags, set wins over clear
    // =========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            host_to_micro_full <= FLAG_RST;
        end else if (h_wr_data) begin
            host_to_micro_full <= 1'b1;
        end else if (m_rd_data) begin
            host_to_micro_full <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            micro_to_host_full <= FLAG_RST;
        end else if (m_wr_data) begin
            micro_to_host_full <= 1'b1;
        end else if (h_rd_data) begin
            micro_to_host_full <= 1'b0;
        end
    end

    // =========================================================
    // Read paths
    // =========================================================
    function automatic logic [DATA_W-1:0] port_view(
        input logic [MID_HI:MID_LO] mid,
        input logic lo_flag,
        input logic hi_flag
    );
        port_view = {hi_flag, mid, lo_flag};
    endfunction

    // Host read data held while strobe stays high
    always_ff @(posedge clk) begin
        if (rst) begin
            host_rdata <= DATA_RST;
        end else if (h_rd_data) begin
            host_rdata <= m2h_data_q;
        end else if (h_rd_rep) begin
            host_rdata <= port_view(rep_mid_q, micro_to_host_full,
                host_to_micro_full);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            host_rdata_oe_n <= 1'b1;
        end else if (hrd_p) begin
            host_rdata_oe_n <= ~sel_match;
        end else if (!hrd_lvl) begin
            host_rdata_oe_n <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            micro_rdata <= DATA_RST;
        end else if (m_rd_data) begin
            micro_rdata <= h2m_data_q;
        end else if (m_rd_cmd) begin
            micro_rdata <= port_view(cmd_mid_q, micro_to_host_full,
                host_to_micro_full);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            micro_rdata_oe_n <= 1'b1;
        end else if (mrd_p) begin
            micro_rdata_oe_n <= 1'b0;
        end else if (!mrd_lvl) begin
            micro_rdata_oe_n <= 1'b1;
        end
    end

endmodule // hmbt_translator

// ===== sim/hmbt_chk.sv
// Checker: port-level properties of the bus translator
module hmbt_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] host_address_bits,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic card_selected,
    input wire logic host_rdata_oe_n,
    input wire logic [7:0] host_rdata,
    input wire logic host_attention_request,
    input wire logic host_halt_request,
    input wire logic [7:0] micro_addr,
    input wire logic micro_rd,
    input wire logic micro_wr,
    input wire logic [7:0] micro_wdata,
    input wire logic [7:0] micro_rdata,
    input wire logic micro_rdata_oe_n,
    input wire logic host_to_micro_full,
    input wire logic micro_to_host_full
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // ==========================================
    // Flags and requests
    AST_RST: assert property (disable iff (1'b0) rst |=>
        !host_to_micro_full && !micro_to_host_full && !host_halt_request)
        else $error("flag or request set after reset");
    AST_H2M_SET: assert property ($rose(host_wr) && card_selected
        && host_address_bits[0] |-> ##[3:5] host_to_micro_full)
        else $error("host data write left flag clear");
    AST_H2M_CLR: assert property ($rose(micro_rd) && micro_addr[0]
        |-> ##[3:5] !host_to_micro_full)
        else $error("micro data read left flag set");
    AST_M2H_SET: assert property ($rose(micro_wr) && micro_addr[0]
        |-> ##[3:5] micro_to_host_full)
        else $error("micro data write left flag clear");
    AST_M2H_CLR: assert property ($rose(host_rd) && card_selected
        && host_address_bits[0] |-> ##[3:5] !micro_to_host_full)
        else $error("host data read left flag set");
    AST_MRD: assert property ($fell(micro_rdata_oe_n) && !micro_addr[0]
        |-> micro_rdata[0] == micro_to_host_full
        && micro_rdata[7] == host_to_micro_full)
        else $error("micro command read flag bits wrong");
    AST_HRD: assert property ($fell(host_rdata_oe_n)
        && !host_address_bits[0] |-> host_rdata[0] == micro_to_host_full
        && host_rdata[7] == host_to_micro_full)
        else $error("host report read flag bits wrong");
    AST_REQ: assert property ($rose(micro_wr) && !micro_addr[0]
        |-> ##5 host_attention_request == micro_wdata[0]
        && host_halt_request == micro_wdata[7])
        else $error("host request lines do not follow report write");
endmodule // hmbt_chk

// ===== sim/hmbt_micro_model.sv
// Card microcomputer model: byte accesses on its own bus
module hmbt_micro_model (
    input wire logic clk,
    output logic [7:0] micro_addr,
    output logic micro_rd,
    output logic micro_wr,
    output logic [7:0] micro_wdata,
    input wire logic [7:0] micro_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        micro_addr = 8'h00;
        micro_rd = 1'b0;
        micro_wr = 1'b0;
        micro_wdata = 8'h00;
    end
    task automatic acc(input logic wr, input logic a0,
                       input logic [7:0] d, output logic [7:0] r);
        @(negedge clk);
        micro_addr = {7'h00, a0};
        micro_wdata = d;
        repeat (3) @(negedge clk);
        micro_wr = wr;
        micro_rd = !wr;
        repeat (6) @(negedge clk);
        r = micro_rdata;
        micro_wr = 1'b0;
        micro_rd = 1'b0;
        micro_wdata = ~d;
        repeat (5) @(negedge clk);
    endtask
endmodule // hmbt_micro_model

// ===== sim/tb.sv
// Testbench top: host and micro mailbox scenarios
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] host_address_bits = 4'h0;
    logic host_rd = 1'b0;
    logic host_wr = 1'b0;
    logic [7:0] host_wdata = 8'h00;
    logic [2:0] select_code_switches = 3'h2;
    logic [7:0] host_rdata, micro_addr, micro_wdata, micro_rdata, q, c;
    logic host_rdata_oe_n, card_selected, host_attention_request;
    logic host_halt_request, micro_rd, micro_wr, micro_rdata_oe_n;
    logic micro_attention_request, micro_reset;
    logic host_to_micro_full, micro_to_host_full;
    logic [7:0] cv [2] = '{8'h81, 8'h7E};
    int error_cnt = 0;
    int check_count = 0;
    initial begin
        forever #20 clk = ~clk;
    end
    hmbt_translator u_dut (.clk, .rst, .host_address_bits, .host_rd,
        .host_wr, .host_wdata, .host_rdata, .host_rdata_oe_n,
        .select_code_switches, .card_selected, .host_attention_request,
        .host_halt_request, .micro_addr, .micro_rd, .micro_wr,
        .micro_wdata, .micro_rdata, .micro_rdata_oe_n,
        .micro_attention_request, .micro_reset, .host_to_micro_full,
        .micro_to_host_full);
    hmbt_micro_model u_mic (.clk, .micro_addr, .micro_rd, .micro_wr,
        .micro_wdata, .micro_rdata);
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task hacc(input logic wr, input logic a0, input logic [7:0] d,
              output logic [7:0] r);
        @(negedge clk);
        host_address_bits = {3'h2, a0};
        host_wdata = d;
        repeat (3) @(negedge clk);
        host_wr = wr;
        host_rd = !wr;
        repeat (6) @(negedge clk);
        r = host_rdata;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = ~d;
        repeat (5) @(negedge clk);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk({host_to_micro_full, micro_to_host_full, host_rdata_oe_n,
            micro_rdata_oe_n, micro_reset, micro_attention_request,
            host_halt_request, host_attention_request}, 8'h30);
        $display("test reset done");
        foreach (cv[i]) begin
            c = cv[i];
            hacc(1'b1, 1'b0, c, q);
            chk({micro_reset, micro_attention_request}, {c[7], c[0]});
            u_mic.acc(1'b0, 1'b0, 8'h00, q);
            chk(q, {1'b0, c[6:1], 1'b0});
        end
        hacc(1'b1, 1'b1, 8'hA5, q);
        chk({7'h00, host_to_micro_full}, 8'h01);
        chk({7'h00, card_selected}, 8'h01);
        u_mic.acc(1'b0, 1'b0, 8'h00, q);
        chk(q, {1'b1, c[6:1], 1'b0});
        u_mic.acc(1'b0, 1'b1, 8'h00, q);
        chk(q, 8'hA5);
        chk({7'h00, host_to_micro_full}, 8'h00);
        $display("test host to micro done");
        foreach (cv[i]) begin
            c = cv[i];
            u_mic.acc(1'b1, 1'b0, c, q);
            chk({host_halt_request, host_attention_request}, {c[7], c[0]});
            hacc(1'b0, 1'b0, 8'h00, q);
            chk(q, {1'b0, c[6:1], 1'b0});
        end
        u_mic.acc(1'b1, 1'b1, 8'h3C, q);
        chk({7'h00, micro_to_host_full}, 8'h01);
        hacc(1'b0, 1'b0, 8'h00, q);
        chk(q, {1'b0, c[6:1], 1'b1});
        hacc(1'b0, 1'b1, 8'h00, q);
        chk(q, 8'h3C);
        chk({7'h00, micro_to_host_full}, 8'h00);
        $display("test micro to host done");
        select_code_switches = 3'h5;
        hacc(1'b1, 1'b1, 8'h11, q);
        chk({card_selected, host_to_micro_full}, 8'h00);
        hacc(1'b0, 1'b0, 8'h00, q);
        chk(q, 8'h3C);
        $display("test select mismatch done");
        summarize();
    end
endmodule // tb
bind hmbt_translator hmbt_chk u_chk (.clk, .rst, .host_address_bits,
    .host_rd, .host_wr, .card_selected, .host_rdata_oe_n, .host_rdata,
    .host_attention_request, .host_halt_request, .micro_addr, .micro_rd,
    .micro_wr, .micro_wdata, .micro_rdata, .micro_rdata_oe_n,
    .host_to_micro_full, .micro_to_host_full);
